// *** ddi_mode_regs.sv ***
// mode register bank: device info (read-only) and two feature registers
`timescale 1ns/1ns
module ddi_mode_regs
  import ddi_pkg::*;
#(
  parameter int         INIT_CYC  = DDI_INIT_CYC,
  parameter logic       HAS_SETB  = 1'b1,
  parameter logic       HAS_LOWLT = 1'b1,
  parameter logic       HAS_ZQST  = 1'b1
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  ddi_cmd_s         cmd,
  input  wire logic [1:0]  zq_pin_state,
  input  wire logic        burst_start,
  input  wire logic [1:0]  burst_col,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output ddi_cfg_s         cfg,
  output logic             use_factory_trim,
  output logic             burst_active,
  output logic [2:0]       burst_addr
);
  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_ZQ   = 3'b100
  } ddi_state_e;

  ddi_state_e   st_q;
  ddi_state_e   st_d;
  logic [31:0]  cnt_q;
  logic [31:0]  cnt_d;
  logic [1:0]   zq_q;
  logic         trim_q;
  logic [7:0]   f1_q;
  logic [7:0]   f2_q;
  logic         rdv_q;
  logic [7:0]   rdd_q;
  logic         bact_q;
  logic [2:0]   badr_q;
  ddi_cfg_s     cfg_q;
  logic         b_act;
  logic [2:0]   b_col;

  // write recovery decode, reserved codes flagged invalid
  function automatic logic [5:0] wr_decode(input logic ext, input logic [2:0] c);
    logic [5:0] r;
    r = 6'h00;
    if (!ext) begin
      case (c)
        3'h1:    r = {1'b1, 5'd3};
        3'h4:    r = {1'b1, 5'd6};
        3'h6:    r = {1'b1, 5'd8};
        3'h7:    r = {1'b1, 5'd9};
        default: r = 6'h00;
      endcase
    end else begin
      case (c)
        3'h0:    r = {1'b1, 5'd10};
        3'h1:    r = {1'b1, 5'd11};
        3'h2:    r = {1'b1, 5'd12};
        3'h4:    r = {1'b1, 5'd14};
        3'h6:    r = {1'b1, 5'd16};
        default: r = 6'h00;
      endcase
    end
    return r;
  endfunction

  wire        wr_cmd   = cmd.valid & cmd.write;
  wire        rd_cmd   = cmd.valid & ~cmd.write;
  wire        wr_f1    = wr_cmd & (cmd.addr == DDI_ADDR_FEAT1);
  wire        wr_f2    = wr_cmd & (cmd.addr == DDI_ADDR_FEAT2);
  // reserved bit 4 forced to zero, burst length held at eight beats
  wire [7:0]  f1_in    = {cmd.data[7:5], 1'b0, cmd.data[3], DDI_BL8};
  wire [7:0]  f2_in    = {cmd.data[7:6], 1'b0, cmd.data[4:0]};
  wire        zq_cmd   = wr_cmd & (cmd.addr == DDI_ADDR_CALIB) & (cmd.data == DDI_CAL_INIT);
  // assembly fault latches trim and blocks calibration
  wire        zq_take  = zq_cmd & ~trim_q & HAS_ZQST;
  wire        zq_fault = (zq_pin_state == DDI_ZQ_SUPPLY) | (zq_pin_state == DDI_ZQ_GND);
  wire        zq_done  = (st_q == ST_ZQ) & (cnt_q == 32'h0);
  wire [5:0]  wr_dec   = wr_decode(f2_q[DDI_F2_WRE], f1_q[7:5]);
  wire        init_run = (st_q == ST_INIT);

  // info register: reserved bits read zero
  wire [7:0]  info_val = {HAS_LOWLT, HAS_SETB, 1'b0, zq_q, 2'b00, init_run};
  // write-only and unmapped addresses return zero rather than undefined data
  wire [7:0]  rd_sel   = (cmd.addr == DDI_ADDR_INFO) ? info_val : 8'h00;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_INIT: begin
        if (cnt_q == 32'h0) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      ST_IDLE: begin
        if (zq_take) begin
          st_d  = ST_ZQ;
          cnt_d = DDI_ZQI_CYC - 1;
        end
      end
      ST_ZQ: begin
        if (cnt_q == 32'h0) begin
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        cnt_d = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= ST_INIT;
      cnt_q <= INIT_CYC - 1;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // self-test field moves only at end of init calibration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zq_q   <= DDI_ZQ_NONE;
      trim_q <= 1'b0;
    end else if (zq_done) begin
      zq_q   <= zq_pin_state;
      trim_q <= zq_fault;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      f1_q <= DDI_FEAT1_RST;
      f2_q <= DDI_FEAT2_RST;
    end else begin
      if (wr_f1) begin
        f1_q <= f1_in;
      end
      if (wr_f2) begin
        f2_q <= f2_in;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdv_q <= 1'b0;
      rdd_q <= 8'h00;
    end else begin
      rdv_q <= rd_cmd;
      rdd_q <= rd_cmd ? rd_sel : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
    end else begin
      cfg_q.leveling  <= f2_q[DDI_F2_LEV];
      cfg_q.wl_set_b  <= f2_q[DDI_F2_WLS] & HAS_SETB;
      cfg_q.wr_ext    <= f2_q[DDI_F2_WRE];
      cfg_q.latency   <= f2_q[3:0];
      cfg_q.wr_cycles <= wr_dec[4:0];
      cfg_q.wr_valid  <= wr_dec[5];
    end
  end

  ddi_burst_order u_burst (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (burst_start),
    .col_c2c1 (burst_col),
    .active   (b_act),
    .col      (b_col)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bact_q <= 1'b0;
      badr_q <= 3'h0;
    end else begin
      bact_q <= b_act;
      badr_q <= b_col;
    end
  end

  assign rd_valid         = rdv_q;
  assign rd_data          = rdd_q;
  assign cfg              = cfg_q;
  assign use_factory_trim = trim_q;
  assign burst_active     = bact_q;
  assign burst_addr       = badr_q;
endmodule

// *** ddi_pkg.sv ***
// constants and types for the device info and feature mode registers
package ddi_pkg;
  localparam logic [7:0] DDI_ADDR_INFO   = 8'h00;
  localparam logic [7:0] DDI_ADDR_FEAT1  = 8'h01;
  localparam logic [7:0] DDI_ADDR_FEAT2  = 8'h02;
  localparam logic [7:0] DDI_ADDR_CALIB  = 8'h0A;
  localparam logic [7:0] DDI_CAL_INIT    = 8'hFF;
  localparam logic [7:0] DDI_FEAT1_RST   = 8'h03;
  localparam logic [7:0] DDI_FEAT2_RST   = 8'h18;
  localparam logic [2:0] DDI_BL8         = 3'h3;
  localparam int         DDI_INFO_DONE   = 0;
  localparam int         DDI_INFO_ZQLO   = 3;
  localparam int         DDI_INFO_SETB   = 6;
  localparam int         DDI_INFO_LOWLAT = 7;
  localparam int         DDI_F2_WRE      = 4;
  localparam int         DDI_F2_WLS      = 6;
  localparam int         DDI_F2_LEV      = 7;
  localparam logic [1:0] DDI_ZQ_NONE     = 2'h0;
  localparam logic [1:0] DDI_ZQ_SUPPLY   = 2'h1;
  localparam logic [1:0] DDI_ZQ_GND      = 2'h2;
  localparam logic [1:0] DDI_ZQ_PASS     = 2'h3;
  localparam int         DDI_CLK_MHZ     = 50;
  localparam int         DDI_INIT_US     = 200;
  localparam int         DDI_INIT_CYC    = DDI_INIT_US * DDI_CLK_MHZ;
  localparam int         DDI_ZQI_NS      = 1000;
  localparam int         DDI_ZQI_CYC     = (DDI_ZQI_NS * DDI_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] data;
  } ddi_cmd_s;

  typedef struct packed {
    logic       leveling;
    logic       wl_set_b;
    logic       wr_ext;
    logic [3:0] latency;
    logic [4:0] wr_cycles;
    logic       wr_valid;
  } ddi_cfg_s;
endpackage

// *** ddi_burst_order.sv ***
// burst column order generator for eight-beat sequential bursts
`timescale 1ns/1ns
module ddi_burst_order
  import ddi_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [1:0]  col_c2c1,
  output logic             active,
  output logic [2:0]       col
);
  logic [2:0] beat_q;
  logic [2:0] base_q;
  logic       act_q;
  wire  [2:0] base_in = {col_c2c1, 1'b0};
  wire  [2:0] beat_nx = beat_q + 3'h1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      beat_q <= 3'h0;
      base_q <= 3'h0;
      act_q  <= 1'b0;
    end else if (start) begin
      base_q <= base_in;
      beat_q <= 3'h0;
      act_q  <= 1'b1;
    end else if (act_q) begin
      beat_q <= beat_nx;
      act_q  <= (beat_q != 3'h7);
    end
  end

  assign active = act_q;
  assign col    = base_q + beat_q;   // modulo eight by width
endmodule

// *** ddi_mode_regs_chk.sv ***
// assertion checker for the mode register bank
`timescale 1ns/1ns
module ddi_mode_regs_chk
  import ddi_pkg::*;
#(
  parameter int   INIT_CYC  = 20,
  parameter logic HAS_SETB  = 1'b1,
  parameter logic HAS_LOWLT = 1'b1
)(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input ddi_cmd_s        cmd,
  input wire logic       burst_start,
  input wire logic [1:0] burst_col,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input ddi_cfg_s        cfg,
  input wire logic       use_factory_trim,
  input wire logic       burst_active,
  input wire logic [2:0] burst_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // cycles since reset release, saturating so long runs stay valid
  logic [15:0] cyc_q;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) cyc_q <= 16'h0000;
    else if (cyc_q != 16'hFFFF) cyc_q <= cyc_q + 16'h0001;

  AST_RSVD: assert property (rd_valid |-> rd_data[5] == 1'b0 && rd_data[2:1] == 2'h0)
    else $error("reserved info bits not zero");
  AST_NOTINFO: assert property (cmd.valid && !cmd.write && cmd.addr != DDI_ADDR_INFO
    |=> rd_valid && rd_data == 8'h00)
    else $error("read of non-info register not zero");
  AST_ID: assert property (rd_valid && $past(cmd.addr) == DDI_ADDR_INFO
    |-> rd_data[7:6] == {HAS_LOWLT, HAS_SETB})
    else $error("option support bits wrong");
  AST_INIT_BUSY: assert property (rd_valid && cyc_q < INIT_CYC - 2 |-> rd_data[0])
    else $error("init flag low too early");
  AST_INIT_DONE: assert property (rd_valid && cyc_q > INIT_CYC + 4
    && $past(cmd.addr) == DDI_ADDR_INFO |-> !rd_data[0])
    else $error("init flag still high");
  AST_BURST_LEN: assert property (burst_start |-> ##2 burst_active [*8] ##1 !burst_active)
    else $error("burst not eight beats");
  AST_BURST_START: assert property (burst_start
    |-> ##2 burst_addr == {$past(burst_col, 2), 1'b0})
    else $error("burst start column wrong");
  AST_BURST_STEP: assert property (burst_active && $past(burst_active)
    |-> burst_addr == $past(burst_addr) + 3'h1)
    else $error("burst column not sequential");
  AST_TRIM_HOLD: assert property (use_factory_trim |=> use_factory_trim)
    else $error("factory trim dropped");
  AST_CFG: assert property (cmd.valid && cmd.write && cmd.addr == DDI_ADDR_FEAT2
    |-> ##2 cfg.latency == $past(cmd.data[3:0], 2) && cfg.leveling == $past(cmd.data[7], 2))
    else $error("feature two fields not applied");

  COV_BURST: cover property (burst_start);
  COV_TRIM: cover property ($rose(use_factory_trim));
  COV_READY: cover property (rd_valid && !rd_data[0]);
endmodule

bind ddi_mode_regs ddi_mode_regs_chk #(.INIT_CYC(INIT_CYC), .HAS_SETB(HAS_SETB),
  .HAS_LOWLT(HAS_LOWLT)) u_ddi_mode_regs_chk (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd),
  .burst_start(burst_start), .burst_col(burst_col), .rd_valid(rd_valid), .rd_data(rd_data),
  .cfg(cfg), .use_factory_trim(use_factory_trim), .burst_active(burst_active),
  .burst_addr(burst_addr));

// *** ddi_host_mdl.sv ***
// host controller model issuing mode register commands
`timescale 1ns/1ns
module ddi_host_mdl
  import ddi_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output ddi_cmd_s        cmd
);
  initial cmd = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] w;
    w = d;
    if (a == DDI_ADDR_FEAT1) w = {d[7:5], 1'b0, d[3], DDI_BL8};
    if (a == DDI_ADDR_FEAT2) w[5] = 1'b0;
    @(posedge clk_sys);
    cmd <= '{1'b1, 1'b1, a, w};
    @(posedge clk_sys);
    cmd <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_sys);
    cmd <= '0;
    #1;
    // answer stands one cycle only; a missing answer reads as unknown
    d = rd_valid ? rd_data : 8'hXX;
  endtask
endmodule

// *** tb_ddi_mode_regs.sv ***
// testbench for the mode register bank
`timescale 1ns/1ns
module tb_ddi_mode_regs;
  import ddi_pkg::*;
  localparam int INIT = 20;
  logic       clk_sys, rst_n, burst_start, rd_valid, use_factory_trim, burst_active;
  logic [1:0] zq_pin_state, burst_col;
  logic [7:0] rd_data, v;
  logic [2:0] burst_addr;
  ddi_cmd_s   cmd;
  ddi_cfg_s   cfg;
  int         n_errors = 0, n_checks = 0, cyc = 0;
  logic [3:0] code [9] = '{4'h1, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE};
  logic [4:0] write_recovery_cycles [9] = '{5'h03, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h10};

  ddi_mode_regs #(.INIT_CYC(INIT)) u_ddi_mode_regs (.clk_sys(clk_sys), .rst_n(rst_n),
    .cmd(cmd), .zq_pin_state(zq_pin_state), .burst_start(burst_start),
    .burst_col(burst_col), .rd_valid(rd_valid), .rd_data(rd_data), .cfg(cfg),
    .use_factory_trim(use_factory_trim), .burst_active(burst_active),
    .burst_addr(burst_addr));
  ddi_host_mdl u_ddi_host_mdl (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
    .cmd(cmd));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cal(input logic [1:0] z, input logic [1:0] ex, input logic tr);
    zq_pin_state <= z;
    u_ddi_host_mdl.wr(DDI_ADDR_CALIB, DDI_CAL_INIT);
    repeat (DDI_ZQI_CYC + 4) @(posedge clk_sys);
    u_ddi_host_mdl.rd(DDI_ADDR_INFO, v);
    chk({v[4:3], use_factory_trim}, {ex, tr});
  endtask
  task automatic rst_wait();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // a hang past this many cycles ends the run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    burst_start = 1'b0;
    burst_col = 2'h0;
    zq_pin_state = 2'h3;
    rst_wait();
    #1 chk(16'(cfg), 16'h0615);
    u_ddi_host_mdl.rd(DDI_ADDR_INFO, v);
    chk(v & 8'hC1, 8'hC1);
    u_ddi_host_mdl.wr(DDI_ADDR_INFO, 8'h3E);
    repeat (INIT) @(posedge clk_sys);
    u_ddi_host_mdl.rd(DDI_ADDR_INFO, v);
    chk(v & 8'hE7, 8'hC0);
    u_ddi_host_mdl.rd(DDI_ADDR_FEAT1, v);
    chk(v, 8'h00);
    for (int i = 0; i < 9; i++) begin
      u_ddi_host_mdl.wr(DDI_ADDR_FEAT2, {3'h0, code[i][3], 4'h8});
      u_ddi_host_mdl.wr(DDI_ADDR_FEAT1, {code[i][2:0], 5'h03});
      repeat (3) @(posedge clk_sys);
      chk({cfg.wr_cycles, cfg.wr_valid}, {write_recovery_cycles[i], 1'b1});
    end
    u_ddi_host_mdl.wr(DDI_ADDR_FEAT2, 8'hE5);
    repeat (3) @(posedge clk_sys);
    chk({cfg.leveling, cfg.wl_set_b, cfg.wr_ext, cfg.latency}, 7'h65);
    u_ddi_host_mdl.wr(DDI_ADDR_FEAT1, 8'h0B);
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys);
      burst_start <= 1'b1;
      burst_col <= 2'(c);
      @(posedge clk_sys);
      burst_start <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        @(posedge clk_sys);
        #1 chk({burst_active, burst_addr}, {1'b1, 3'(2 * c + i)});
      end
      @(posedge clk_sys);
      #1 chk(burst_active, 1'b0);
    end
    cal(2'h3, 2'h3, 1'b0);
    cal(2'h2, 2'h2, 1'b1);
    cal(2'h3, 2'h2, 1'b1);
    rst_wait();
    chk(use_factory_trim, 1'b0);
    repeat (INIT) @(posedge clk_sys);
    cal(2'h1, 2'h1, 1'b1);
    print_verdict();
  end
endmodule
